//--- rtl/sig_gate_ctrl.sv
// Window, polarity, signature and lamp control of a signature analyzer.
// Assumes key, switch, get and clear inputs are one-cycle pulses on clk_i;
// timing leads and probe comparators are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module sig_gate_ctrl
   import sig_gate_pkg::*;
#(
   parameter int FLASH_CYCLES = FLASH_CYC,
   parameter int BLINK_CYCLES = BLINK_CYC
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic clock_lead_i,
   input wire logic window_open_close_lead_i,
   input wire logic stop_qual_lead_i,
   input wire logic probe_hi_i,
   input wire logic probe_lo_i,
   input wire logic key_clock_pol_i,
   input wire logic key_start_pol_i,
   input wire logic key_stop_pol_i,
   input wire logic key_qual_pol_i,
   input wire logic key_hold_i,
   input wire logic key_sticky_i,
   input wire logic key_qual_mode_i,
   input wire logic probe_switch_i,
   input wire logic remote_get_i,
   input wire logic clear_i,
   output logic clock_pol_lamp_o,
   output logic start_pol_lamp_o,
   output logic stop_pol_lamp_o,
   output logic qual_pol_lamp_o,
   output logic hold_lamp_o,
   output logic sticky_lamp_o,
   output logic qual_mode_lamp_o,
   output logic [SIG_W-1:0] signature_o,
   output logic sig_update_o,
   output logic sig_triggered_o,
   output logic store_sig_o,
   output logic memory_clear_o,
   output logic busy_o,
   output logic mismatch_lamp_o,
   output logic gate_lamp_o,
   output logic probe_bright_o,
   output logic probe_dim_o,
   output logic probe_flash_o
);
   logic [IN_N-1:0] pin_async, pin_lvl, pin_rise, pin_fall;
   assign pin_async = {probe_lo_i, probe_hi_i, stop_qual_lead_i,
                       window_open_close_lead_i, clock_lead_i};

   genvar gi;
   generate
      for (gi = 0; gi < IN_N; gi++) begin : g_sync
         sig_sync u_sync (
            .clk_i(clk_i),
            .resetn_i(resetn_i),
            .ce_i(ce_i),
            .async_i(pin_async[gi]),
            .level_o(pin_lvl[gi]),
            .rise_o(pin_rise[gi]),
            .fall_o(pin_fall[gi])
         );
      end
   endgenerate

   // Picks the selected edge of a lead; used for the clock, start and stop events
   function automatic logic sel_edge(input logic pol, input logic rise,
                                     input logic fall);
      sel_edge = pol ? rise : fall;
   endfunction

   // Settings
   logic clock_pol_ff, start_pol_ff, stop_pol_ff, qual_pol_ff;
   logic hold_ff, sticky_ff, qual_mode_ff;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         clock_pol_ff <= POL_RESET;
         start_pol_ff <= POL_RESET;
         stop_pol_ff <= POL_RESET;
         qual_pol_ff <= POL_RESET;
         qual_mode_ff <= MODE_RESET;
      end else if (ce_i) begin
         if (key_clock_pol_i) begin
            clock_pol_ff <= ~clock_pol_ff;
         end
         if (key_start_pol_i) begin
            start_pol_ff <= ~start_pol_ff;
         end
         if (key_stop_pol_i) begin
            stop_pol_ff <= ~stop_pol_ff;
         end
         if (key_qual_pol_i && qual_mode_ff) begin
            qual_pol_ff <= ~qual_pol_ff;
         end
         if (key_qual_mode_i) begin
            qual_mode_ff <= ~qual_mode_ff;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         hold_ff <= MODE_RESET;
         sticky_ff <= MODE_RESET;
      end else if (ce_i) begin
         if (key_hold_i) begin
            hold_ff <= ~hold_ff;
         end
         if (key_sticky_i) begin
            sticky_ff <= ~sticky_ff;
         end
      end
   end

   // Qualifier and edge selection
   logic start_evt, stop_evt, clk_evt, qual_ok;

   always_comb begin
      qual_ok = 1'b1;
      start_evt = sel_edge(start_pol_ff, pin_rise[IN_START], pin_fall[IN_START]);
      if (qual_mode_ff) begin
         // Start lead carries both events, stop lead becomes the qualifier
         stop_evt = sel_edge(stop_pol_ff, pin_rise[IN_START], pin_fall[IN_START]);
         qual_ok = (pin_lvl[IN_STOP] == qual_pol_ff);
      end else begin
         stop_evt = sel_edge(stop_pol_ff, pin_rise[IN_STOP], pin_fall[IN_STOP]);
      end
      clk_evt = sel_edge(clock_pol_ff, pin_rise[IN_CLK], pin_fall[IN_CLK]) & qual_ok;
   end

   // Window state machine
   win_state_t state_ff, nxt_state;
   logic [SIG_W-1:0] shift_ff;
   logic clk_seen_ff, trig_pend_ff, trig_win_ff;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         WIN_IDLE: begin
            if (start_evt) begin
               nxt_state = WIN_OPEN;
            end
         end
         WIN_OPEN: begin
            // In qualifier mode the opening edge must not also close
            if (stop_evt) begin
               nxt_state = WIN_DONE;
            end
         end
         WIN_DONE: begin
            nxt_state = WIN_IDLE;
         end
         default: begin
            nxt_state = WIN_IDLE;
         end
      endcase
      if (clear_i) begin
         nxt_state = WIN_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_ff <= WIN_IDLE;
      end else if (ce_i) begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         shift_ff <= SIG_CLEAR;
         clk_seen_ff <= 1'b0;
      end else if (ce_i) begin
         if (state_ff == WIN_IDLE && start_evt) begin
            shift_ff <= SIG_CLEAR;
            clk_seen_ff <= 1'b0;
         end else if (state_ff == WIN_OPEN && clk_evt) begin
            shift_ff <= {shift_ff[SIG_W-2:0], pin_lvl[IN_PHI] ^ shift_ff[TAP_A] ^
                         shift_ff[TAP_B] ^ shift_ff[TAP_C] ^ shift_ff[TAP_D]};
            clk_seen_ff <= 1'b1;
         end
      end
   end

   // A press arms the next window to open; set wins over consumption
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         trig_pend_ff <= 1'b0;
         trig_win_ff <= 1'b0;
      end else if (ce_i) begin
         if (clear_i) begin
            trig_pend_ff <= 1'b0;
            trig_win_ff <= 1'b0;
         end else begin
            if (state_ff == WIN_IDLE && start_evt) begin
               trig_win_ff <= trig_pend_ff;
            end
            if (probe_switch_i || remote_get_i) begin
               trig_pend_ff <= 1'b1;
            end else if (state_ff == WIN_IDLE && start_evt) begin
               trig_pend_ff <= 1'b0;
            end
         end
      end
   end

   // Signature capture and comparison
   logic done, unstable, have_prev_ff, cur_unstable_ff, latch_ff;
   logic [SIG_W-1:0] prev_sig_ff, disp_ff;
   logic upd_ff, trig_out_ff, store_ff, mclr_ff;
   assign done = (state_ff == WIN_DONE) && !clear_i;
   assign unstable = have_prev_ff && (shift_ff != prev_sig_ff);

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         prev_sig_ff <= SIG_CLEAR;
         have_prev_ff <= 1'b0;
         cur_unstable_ff <= 1'b0;
      end else if (ce_i) begin
         if (clear_i) begin
            have_prev_ff <= 1'b0;
            cur_unstable_ff <= 1'b0;
         end else if (done) begin
            // Every signature is compared, triggered or not
            prev_sig_ff <= shift_ff;
            have_prev_ff <= 1'b1;
            cur_unstable_ff <= unstable;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         latch_ff <= 1'b0;
      end else if (ce_i) begin
         // A lamp already lit when sticky mode starts is held as well
         if (sticky_ff && !clear_i && ((done && unstable) || cur_unstable_ff)) begin
            latch_ff <= 1'b1;
         end else if (clear_i || !sticky_ff) begin
            latch_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         disp_ff <= SIG_CLEAR;
         upd_ff <= 1'b0;
         trig_out_ff <= 1'b0;
         store_ff <= 1'b0;
         mclr_ff <= 1'b0;
      end else if (ce_i) begin
         upd_ff <= 1'b0;
         store_ff <= 1'b0;
         mclr_ff <= clear_i;
         if (clear_i) begin
            disp_ff <= SIG_CLEAR;
            trig_out_ff <= 1'b0;
         end else if (done && (!hold_ff || trig_win_ff)) begin
            disp_ff <= shift_ff;
            upd_ff <= 1'b1;
            trig_out_ff <= trig_win_ff;
            store_ff <= trig_win_ff;
         end
      end
   end

   // Window lamp: a completed window that saw a clock edge starts a blink period if none is running
   logic [CNT_W-1:0] blink_ff;
   logic gate_ff;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         blink_ff <= '0;
         gate_ff <= 1'b0;
      end else if (ce_i) begin
         if (blink_ff == '0) begin
            if (done && clk_seen_ff) begin
               blink_ff <= CNT_W'(BLINK_CYCLES);
            end
         end else begin
            blink_ff <= blink_ff - CNT_W'(1);
         end
         // Lit in the first half only, so steady gating shows as a blink
         gate_ff <= (blink_ff > CNT_W'(BLINK_CYCLES / 2));
      end
   end

   // Probe lamp: stretched flash on any change of the sensed level
   logic [CNT_W-1:0] flash_ff;
   logic bright_ff, dim_ff, flash_out_ff, probe_act;

   assign probe_act = pin_rise[IN_PHI] | pin_fall[IN_PHI] |
                      pin_rise[IN_PLO] | pin_fall[IN_PLO];

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         flash_ff <= '0;
         flash_out_ff <= 1'b0;
      end else if (ce_i) begin
         // Retrigger is ignored while flashing, so the flash length is fixed
         if (flash_ff != '0) begin
            flash_ff <= flash_ff - CNT_W'(1);
         end else if (probe_act) begin
            flash_ff <= CNT_W'(FLASH_CYCLES);
         end
         flash_out_ff <= (flash_ff != '0);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         bright_ff <= 1'b0;
         dim_ff <= 1'b0;
      end else if (ce_i) begin
         bright_ff <= pin_lvl[IN_PHI];
         dim_ff <= ~pin_lvl[IN_PHI] & ~pin_lvl[IN_PLO];
      end
   end

   assign clock_pol_lamp_o = clock_pol_ff;
   assign start_pol_lamp_o = start_pol_ff;
   assign stop_pol_lamp_o = stop_pol_ff;
   assign qual_pol_lamp_o = qual_pol_ff;
   assign hold_lamp_o = hold_ff;
   assign sticky_lamp_o = sticky_ff;
   assign qual_mode_lamp_o = qual_mode_ff;
   assign signature_o = disp_ff;
   assign sig_update_o = upd_ff;
   assign sig_triggered_o = trig_out_ff;
   assign store_sig_o = store_ff;
   assign memory_clear_o = mclr_ff;
   assign busy_o = (state_ff == WIN_OPEN);
   assign mismatch_lamp_o = cur_unstable_ff | latch_ff;
   assign gate_lamp_o = gate_ff;
   assign probe_bright_o = bright_ff;
   assign probe_dim_o = dim_ff;
   assign probe_flash_o = flash_out_ff;
endmodule
`default_nettype wire

//--- rtl/sig_gate_pkg.sv
// Shared constants for the signature gate control block.
// Assumes a 125 MHz system clock; all lamp timing is derived from it.
package sig_gate_pkg;
   localparam int CLK_PERIOD_NS = 8;
   // Probe activity flash and window lamp blink length, in microseconds
   localparam int FLASH_TIME_US = 50000;
   localparam int BLINK_TIME_US = 100000;
   localparam int FLASH_CYC = (FLASH_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int BLINK_CYC = (BLINK_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int CNT_W = 24;

   localparam int SIG_W = 16;
   // Feedback taps of the signature register
   localparam int TAP_A = 6;
   localparam int TAP_B = 8;
   localparam int TAP_C = 11;
   localparam int TAP_D = 15;
   localparam logic [SIG_W-1:0] SIG_CLEAR = 16'h0000;

   // Power-up polarities: 1 = rising edge / high level
   localparam logic POL_RESET = 1'b1;
   localparam logic MODE_RESET = 1'b0;

   // Index of each synchronised outside input
   localparam int IN_CLK = 0;
   localparam int IN_START = 1;
   localparam int IN_STOP = 2;
   localparam int IN_PHI = 3;
   localparam int IN_PLO = 4;
   localparam int IN_N = 5;

   typedef enum logic [1:0] {
      WIN_IDLE = 2'b00,
      WIN_OPEN = 2'b01,
      WIN_DONE = 2'b10
   } win_state_t;
endpackage

//--- rtl/sig_sync.sv
// Three-stage synchroniser with a filtered level and edge pulses.
// Assumes the input is asynchronous to clk_i; output changes only when
// the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module sig_sync (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic async_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic level_ff;
   logic rise_ff;
   logic fall_ff;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else if (ce_i) begin
         s1_ff <= async_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         level_ff <= 1'b0;
         rise_ff <= 1'b0;
         fall_ff <= 1'b0;
      end else if (ce_i) begin
         rise_ff <= 1'b0;
         fall_ff <= 1'b0;
         if (s2_ff == s3_ff && s3_ff != level_ff) begin
            level_ff <= s3_ff;
            rise_ff <= s3_ff;
            fall_ff <= ~s3_ff;
         end
      end
   end

   assign level_o = level_ff;
   assign rise_o = rise_ff;
   assign fall_o = fall_ff;
endmodule
`default_nettype wire

//--- sim/sig_gate_checker.sv
// Concurrent checks on the signature gate control ports.
// Assumes a single clk_i domain with ce_i held high by the bench.
`timescale 1ns/1ps
`default_nettype none
module sig_gate_checker (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic key_clock_pol_i,
   input wire logic key_qual_pol_i,
   input wire logic key_hold_i,
   input wire logic key_sticky_i,
   input wire logic clear_i,
   input wire logic clock_pol_lamp_o,
   input wire logic qual_pol_lamp_o,
   input wire logic hold_lamp_o,
   input wire logic sticky_lamp_o,
   input wire logic qual_mode_lamp_o,
   input wire logic sig_update_o,
   input wire logic sig_triggered_o,
   input wire logic store_sig_o,
   input wire logic memory_clear_o,
   input wire logic busy_o,
   input wire logic mismatch_lamp_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   // A window closed on its own, not through a clear, with hold off
   sequence win_closed_s;
      $fell(busy_o) && !$past(clear_i) && !clear_i ##1 !clear_i && !hold_lamp_o;
   endsequence

   reset_pol_a: assert property ($rose(resetn_i) |-> clock_pol_lamp_o && qual_pol_lamp_o
      && !qual_mode_lamp_o && !hold_lamp_o) else $error("power-up settings wrong");
   clk_toggle_a: assert property (key_clock_pol_i |=> $changed(clock_pol_lamp_o))
      else $error("clock polarity did not toggle");
   clk_keep_a: assert property (!key_clock_pol_i |=> $stable(clock_pol_lamp_o))
      else $error("clock polarity changed without key");
   qual_refuse_a: assert property (key_qual_pol_i && !qual_mode_lamp_o |=>
      $stable(qual_pol_lamp_o)) else $error("qualifier polarity changed outside mode");
   qual_accept_a: assert property (key_qual_pol_i && qual_mode_lamp_o |=>
      $changed(qual_pol_lamp_o)) else $error("qualifier polarity not toggled");
   hold_lamp_a: assert property (key_hold_i |=> $changed(hold_lamp_o))
      else $error("hold lamp did not follow key");
   sticky_keep_a: assert property (sticky_lamp_o && mismatch_lamp_o && !clear_i
      && !key_sticky_i |=> mismatch_lamp_o) else $error("sticky lamp dropped");
   clear_abort_a: assert property (clear_i |=> memory_clear_o && !busy_o)
      else $error("clear did not abort and clear memory");
   hold_trig_a: assert property ($past(hold_lamp_o) && sig_update_o |-> sig_triggered_o)
      else $error("untriggered update while holding");
   store_trig_a: assert property (store_sig_o |-> sig_update_o && sig_triggered_o)
      else $error("store without triggered update");
   close_update_a: assert property (win_closed_s |-> ##[0:1] sig_update_o)
      else $error("closed window gave no signature");
endmodule
`default_nettype wire

//--- sim/uut_model.sv
// Behavioural unit under test driving the timing leads and probe.
// Assumes the bench calls frame() one at a time; leads idle between frames.
`timescale 1ns/1ps
`default_nettype none
module uut_model;
   logic clk_lead = 1'b0;
   logic start_lead = 1'b0;
   logic stop_lead = 1'b0;
   logic p_hi = 1'b0;
   logic p_lo = 1'b0;

   // Lead clock runs only inside the frame; qm puts the qualifier on stop
   task automatic frame(input logic [15:0] d, input logic [15:0] q, input int n, input logic qm);
      start_lead = 1'b1;
      #64;
      if (qm) start_lead = 1'b0;
      #64;
      for (int i = 0; i < n; i++) begin
         p_hi = d[i];
         p_lo = !d[i];
         if (qm) stop_lead = q[i];
         #32 clk_lead = 1'b1;
         #32 clk_lead = 1'b0;
      end
      #32;
      if (qm) start_lead = 1'b1;
      else stop_lead = 1'b1;
      #64 start_lead = 1'b0;
      stop_lead = 1'b0;
      // Released probe floats: neither threshold met
      p_hi = 1'b0;
      p_lo = 1'b0;
      #128;
   endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the signature gate control block.
// Assumes uut_model drives the pins; keys are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import sig_gate_pkg::*;
;
   localparam logic [15:0] D1 = 16'hA5C3;
   localparam logic [15:0] D2 = 16'h3C96;
   localparam logic [15:0] D3 = 16'h5AF0;
   localparam logic [15:0] Q3 = 16'h0F3C;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic [9:0] keys = 10'h000;
   logic [15:0] n_upd = 16'h0000;
   logic [15:0] got = 16'h0000;
   logic got_store = 1'b0;
   logic [1:0] seen = 2'b00;
   int num_errors = 0;
   int compares = 0;
   wire [7:0] lp;
   wire [15:0] sig;
   wire upd, st, gl, fl, pb, pd;

   uut_model u_uut_model();
   sig_gate_ctrl #(.FLASH_CYCLES(20), .BLINK_CYCLES(40)) u_sig_gate_ctrl (
      .clk_i(clk), .resetn_i(resetn), .ce_i(ce), .clock_lead_i(u_uut_model.clk_lead),
      .window_open_close_lead_i(u_uut_model.start_lead),
      .stop_qual_lead_i(u_uut_model.stop_lead),
      .probe_hi_i(u_uut_model.p_hi), .probe_lo_i(u_uut_model.p_lo),
      .key_clock_pol_i(keys[0]), .key_start_pol_i(keys[1]), .key_stop_pol_i(keys[2]),
      .key_qual_pol_i(keys[3]), .key_hold_i(keys[4]), .key_sticky_i(keys[5]),
      .key_qual_mode_i(keys[6]), .probe_switch_i(keys[7]), .remote_get_i(keys[8]),
      .clear_i(keys[9]), .mismatch_lamp_o(lp[7]), .clock_pol_lamp_o(lp[6]),
      .start_pol_lamp_o(lp[5]), .stop_pol_lamp_o(lp[4]), .qual_pol_lamp_o(lp[3]),
      .hold_lamp_o(lp[2]), .sticky_lamp_o(lp[1]), .qual_mode_lamp_o(lp[0]),
      .signature_o(sig), .sig_update_o(upd), .sig_triggered_o(), .store_sig_o(st),
      .memory_clear_o(), .busy_o(), .gate_lamp_o(gl), .probe_bright_o(pb),
      .probe_dim_o(pd), .probe_flash_o(fl)
   );

   always #4 clk = ~clk;
   // Catch one-cycle pulses that the tasks would otherwise miss
   always @(posedge clk) begin
      if (resetn) seen <= seen | {gl, fl};
      if (upd === 1'b1) begin
         n_upd <= n_upd + 16'h0001;
         got <= sig;
         got_store <= st;
      end
   end

   function automatic logic [15:0] sig_of(input logic [15:0] d, q, input logic qm);
      logic [15:0] s;
      s = 16'h0000;
      for (int i = 0; i < 16; i++)
         if (!qm || q[i]) s = {s[14:0], s[TAP_A] ^ s[TAP_B] ^ s[TAP_C] ^ s[TAP_D] ^ d[i]};
      return s;
   endfunction

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic press(input int k);
      @(posedge clk) keys[k] <= 1'b1;
      @(posedge clk) keys[k] <= 1'b0;
      @(negedge clk);
   endtask

   task automatic run(input logic [15:0] d, q, input logic qm, input logic [15:0] nu);
      logic [15:0] b;
      b = n_upd;
      u_uut_model.frame(d, q, 16, qm);
      chk(n_upd - b, nu);
   endtask

   task automatic print_verdict;
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (8) @(negedge clk);
      chk({8'h00, lp}, 16'h0078);
      chk(sig, 16'h0000);
      chk({14'h0, seen}, 16'h0000);
      $display("reset test done");
      for (int k = 0; k < 3; k++) begin
         press(k);
         chk({8'h00, lp}, 16'h0078 ^ (16'h0040 >> k));
         press(k);
      end
      press(3);
      chk({8'h00, lp}, 16'h0078);
      press(6);
      press(3);
      chk({8'h00, lp}, 16'h0071);
      press(3);
      press(6);
      chk({8'h00, lp}, 16'h0078);
      $display("polarity test done");
      run(D1, 16'h0000, 1'b0, 16'h0001);
      chk(got, sig_of(D1, 16'h0000, 1'b0));
      chk({15'h0, got_store}, 16'h0000);
      chk({14'h0, seen}, 16'h0003);
      chk({14'h0, pb, pd}, 16'h0001);
      press(7);
      run(D1, 16'h0000, 1'b0, 16'h0001);
      chk({15'h0, got_store}, 16'h0001);
      chk({8'h00, lp}, 16'h0078);
      $display("measure test done");
      press(4);
      chk({8'h00, lp}, 16'h007C);
      run(D2, 16'h0000, 1'b0, 16'h0000);
      chk(got, sig_of(D1, 16'h0000, 1'b0));
      chk({8'h00, lp}, 16'h00FC);
      press(8);
      run(D2, 16'h0000, 1'b0, 16'h0001);
      chk(got, sig_of(D2, 16'h0000, 1'b0));
      chk({8'h00, lp}, 16'h007C);
      press(4);
      $display("hold test done");
      press(5);
      run(D1, 16'h0000, 1'b0, 16'h0001);
      chk({8'h00, lp}, 16'h00FA);
      run(D1, 16'h0000, 1'b0, 16'h0001);
      chk({8'h00, lp}, 16'h00FA);
      press(9);
      chk({8'h00, lp}, 16'h007A);
      chk(sig, 16'h0000);
      run(D1, 16'h0000, 1'b0, 16'h0001);
      chk({8'h00, lp}, 16'h007A);
      run(D2, 16'h0000, 1'b0, 16'h0001);
      chk({8'h00, lp}, 16'h00FA);
      press(5);
      run(D2, 16'h0000, 1'b0, 16'h0001);
      chk({8'h00, lp}, 16'h0078);
      $display("sticky test done");
      press(6);
      run(D3, Q3, 1'b1, 16'h0001);
      chk(got, sig_of(D3, Q3, 1'b1));
      press(6);
      $display("qualifier test done");
      print_verdict();
   end
endmodule

bind sig_gate_ctrl sig_gate_checker u_sig_gate_checker (
   .clk_i(clk_i), .resetn_i(resetn_i), .key_clock_pol_i(key_clock_pol_i),
   .key_qual_pol_i(key_qual_pol_i), .key_hold_i(key_hold_i), .key_sticky_i(key_sticky_i),
   .clear_i(clear_i), .clock_pol_lamp_o(clock_pol_lamp_o), .qual_pol_lamp_o(qual_pol_lamp_o),
   .hold_lamp_o(hold_lamp_o), .sticky_lamp_o(sticky_lamp_o),
   .qual_mode_lamp_o(qual_mode_lamp_o), .sig_update_o(sig_update_o),
   .sig_triggered_o(sig_triggered_o), .store_sig_o(store_sig_o),
   .memory_clear_o(memory_clear_o), .busy_o(busy_o), .mismatch_lamp_o(mismatch_lamp_o)
);
`default_nettype wire
